// ===== rtl/ppp_pkg.sv
// Shared constants and types of the programming port.
package ppp_pkg;
  // Memory geometry.
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 32768;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Address field positions.
  localparam int A_P2_LSB = 0;
  localparam int A_P2_W = 4;
  localparam int A_P1_LSB = 4;
  localparam int A_P1_W = 7;
  localparam int A_P3_B0 = 11;
  localparam int A_P3_B1 = 12;
  localparam int A_P4_B0 = 13;
  localparam int A_P4_B1 = 14;
  // Layout of the synchronised pin vector.
  localparam int PIN_RST_N = 0;
  localparam int PIN_CE_N = 1;
  localparam int PIN_OE_N = 2;
  localparam int PIN_VPP = 3;
  localparam int PIN_ADDR_LSB = 4;
  localparam int PIN_DATA_LSB = 19;
  localparam int PIN_W = 27;
  localparam logic [7:0] DRIVE_ALL = 8'hFF;
  localparam logic [7:0] DRIVE_NONE = 8'h00;
  // Port mode, one-hot.
  typedef enum logic [4:0] {
    PPP_RUN = 5'h01,
    PPP_IDLE = 5'h02,
    PPP_READ = 5'h04,
    PPP_VERIFY = 5'h08,
    PPP_PROGRAM = 5'h10
  } ppp_state_t;
endpackage

// ===== rtl/ppp_sync_if.sv
// Interface carrying raw pin levels to the synchroniser and the synchronised copy back.
`timescale 1ns/1ps
`default_nettype none
interface ppp_sync_if;
  logic [ppp_pkg::PIN_W-1:0] raw;
  logic [ppp_pkg::PIN_W-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface
`default_nettype wire

// ===== rtl/ppp_sync.sv
// Two-stage synchroniser for the asynchronous programmer pins.
`timescale 1ns/1ps
`default_nettype none
module ppp_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  ppp_sync_if.syn pins
);
  logic [ppp_pkg::PIN_W-1:0] stage1;

  // Pins idle high, so reset loads ones: no enable looks asserted
  // and the reset pin reads as released, keeping the core in run mode.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1 <= '1;
      pins.sync <= '1;
    end
    else if (clk_en)
    begin
      stage1 <= pins.raw;
      pins.sync <= stage1; // Only the second stage reads the first.
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ppp_port.sv
// Programming and readout port of the on-chip program memory.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reset pin held low switches the pins into memory programming mode.
// - Address bits 0 to 3 come from the low four pins of port two.
// - Address bits 4 to 10 come from port one pins 1 to 7.
// - Address bits 11 and 12 come from port three pins 0 and 1.
// - Address bits 13 and 14 come from port four pins 0 and 1.
// - Port zero is the bidirectional eight-bit data bus.
// - Analog reference pin is chip enable, port three pin 2 output enable.
// - Programming voltage on port three pin 3; verify drives the stored byte.
// - Chip and output enable low: the addressed byte is driven out.
// - Without programming voltage the data bus floats whenever chip or output enable is high.
// - Output enable high plus programming voltage selects program mode.
// - In program mode a falling chip enable starts writing the byte.
module ppp_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic vref_ce_n,
  input wire logic [7:0] port_zero_pins_in,
  output logic [7:0] port_zero_pins_out,
  output logic [7:0] port_zero_pins_oe,
  input wire logic [6:0] port_one_upper_pins,
  input wire logic [3:0] port_two_low_pins,
  input wire logic port_three_bit_zero,
  input wire logic port_three_bit_one,
  input wire logic port_three_bit_two,
  input wire logic port_three_bit_three,
  input wire logic port_four_bit_zero,
  input wire logic port_four_bit_one,
  output logic prog_mode,
  output logic write_done
);
  ppp_sync_if pins_if ();
  ppp_pkg::ppp_state_t state;
  ppp_pkg::ppp_state_t next_state;
  logic [ppp_pkg::ADDR_W-1:0] prom_address_bits;
  logic [ppp_pkg::DATA_W-1:0] prom_data_bits;
  logic [ppp_pkg::DATA_W-1:0] mem [0:ppp_pkg::MEM_DEPTH-1];
  logic [ppp_pkg::DATA_W-1:0] rd_data;
  logic rst_pin_s;
  logic ce_n_s;
  logic oe_n_s;
  logic vpp_s;
  logic ce_n_prev;
  logic write_pulse;
  logic drive;

  // Gather every programmer pin into one vector for the synchroniser.
  assign pins_if.raw = {
    port_zero_pins_in,
    port_four_bit_one,
    port_four_bit_zero,
    port_three_bit_one,
    port_three_bit_zero,
    port_one_upper_pins,
    port_two_low_pins,
    port_three_bit_three,
    port_three_bit_two,
    vref_ce_n,
    reset_pin_n
  };

  ppp_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pins(pins_if.syn)
  );

  // Control levels after synchronisation.
  assign rst_pin_s = pins_if.sync[ppp_pkg::PIN_RST_N];
  assign ce_n_s = pins_if.sync[ppp_pkg::PIN_CE_N];
  assign oe_n_s = pins_if.sync[ppp_pkg::PIN_OE_N];
  assign vpp_s = pins_if.sync[ppp_pkg::PIN_VPP];

  // The pin vector was packed so that the synchronised address field
  // already lands in memory order; each slice names its source port.
  always_comb
  begin
    prom_address_bits = '0;
    prom_address_bits[ppp_pkg::A_P2_LSB +: ppp_pkg::A_P2_W] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P2_LSB +: ppp_pkg::A_P2_W];
    prom_address_bits[ppp_pkg::A_P1_LSB +: ppp_pkg::A_P1_W] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P1_LSB +: ppp_pkg::A_P1_W];
    prom_address_bits[ppp_pkg::A_P3_B0] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P3_B0];
    prom_address_bits[ppp_pkg::A_P3_B1] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P3_B1];
    prom_address_bits[ppp_pkg::A_P4_B0] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P4_B0];
    prom_address_bits[ppp_pkg::A_P4_B1] =
      pins_if.sync[ppp_pkg::PIN_ADDR_LSB + ppp_pkg::A_P4_B1];
  end

  // Incoming byte from the data bus.
  assign prom_data_bits = pins_if.sync[ppp_pkg::PIN_DATA_LSB +: ppp_pkg::DATA_W];

  // Mode selection from the enable and voltage levels. Program mode
  // needs output enable high, so a write can never collide with a read.
  always_comb
  begin
    if (rst_pin_s)
    begin
      next_state = ppp_pkg::PPP_RUN;
    end
    else if (vpp_s && oe_n_s)
    begin
      next_state = ppp_pkg::PPP_PROGRAM;
    end
    else if (vpp_s && !oe_n_s)
    begin
      next_state = ppp_pkg::PPP_VERIFY;
    end
    else if (!ce_n_s && !oe_n_s)
    begin
      next_state = ppp_pkg::PPP_READ;
    end
    else
    begin
      next_state = ppp_pkg::PPP_IDLE;
    end
  end

  // Mode register; a low reset pin means programming mode.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ppp_pkg::PPP_RUN;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // Previous chip enable level, for falling-edge detection.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ce_n_prev <= 1'b1;
    end
    else if (clk_en)
    begin
      ce_n_prev <= ce_n_s;
    end
  end

  // A write starts on the falling chip enable while already in program
  // mode; address and data are taken at that same edge.
  assign write_pulse = clk_en && (state == ppp_pkg::PPP_PROGRAM) &&
                       (next_state == ppp_pkg::PPP_PROGRAM) &&
                       ce_n_prev && !ce_n_s;

  // Cells start erased. Programming can only clear bits, as in a real
  // one-time cell, so writing 1 over a programmed 0 fails verify.
  initial
  begin
    for (int i = 0; i < ppp_pkg::MEM_DEPTH; i++)
    begin
      mem[i] = ppp_pkg::ERASED_BYTE;
    end
  end

  // Memory write port.
  always_ff @(posedge sys_clk)
  begin
    if (!rst && write_pulse)
    begin
      mem[prom_address_bits] <= mem[prom_address_bits] & prom_data_bits;
    end
  end

  // Read port, registered so the data pins come from flip-flops.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_data <= ppp_pkg::ERASED_BYTE;
    end
    else if (clk_en)
    begin
      rd_data <= mem[prom_address_bits];
    end
  end

  // Completion flag, one cycle after each committed write.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      write_done <= 1'b0;
    end
    else if (clk_en)
    begin
      write_done <= write_pulse;
    end
  end

  // Output decode from the mode register.
  always_comb
  begin
    case (state)
      ppp_pkg::PPP_READ: drive = 1'b1;
      ppp_pkg::PPP_VERIFY: drive = 1'b1;
      default: drive = 1'b0;
    endcase
  end

  // Data bus outputs; normal operation of the port is not modelled,
  // so outside programming mode the pins are simply released.
  assign port_zero_pins_oe = drive ? ppp_pkg::DRIVE_ALL : ppp_pkg::DRIVE_NONE;
  assign port_zero_pins_out = rd_data;
  assign prog_mode = (state != ppp_pkg::PPP_RUN);

  // Entering programming mode follows the synchronised reset pin.
  chk_mode_entry: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s) |=> prog_mode)
    else $error("programming mode not entered with reset pin low");

  // Reset pin high returns the port to run mode with the bus released.
  chk_mode_exit: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rst_pin_s) |=> (!prog_mode && port_zero_pins_oe == 8'h00))
    else $error("port still active after reset pin released");

  // A read drives the whole bus with the byte at the presented address.
  chk_read_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && !ce_n_s && !oe_n_s && !vpp_s)
    |=> (port_zero_pins_oe == 8'hFF && port_zero_pins_out == mem[$past(prom_address_bits)]))
    else $error("read did not drive the addressed byte");

  // Verify drives the bus even with chip enable high.
  chk_verify_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && vpp_s && !oe_n_s) |=> port_zero_pins_oe == 8'hFF)
    else $error("verify did not drive the data bus");

  // Without programming voltage a high enable floats the bus.
  chk_bus_float: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !vpp_s && (ce_n_s || oe_n_s)) |=> port_zero_pins_oe == 8'h00)
    else $error("data bus driven while an enable is high");

  // Voltage with output enable high selects program mode and no drive.
  chk_prog_enter: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && vpp_s && oe_n_s)
    |=> (state == ppp_pkg::PPP_PROGRAM && port_zero_pins_oe == 8'h00))
    else $error("program mode not selected");

  // A falling chip enable in program mode stores the byte.
  chk_write_start: assert property (@(posedge sys_clk) disable iff (rst)
    write_pulse |=> (write_done &&
      mem[$past(prom_address_bits)] == ($past(mem[prom_address_bits]) & $past(prom_data_bits))))
    else $error("falling chip enable did not store the byte");

  // Outside program mode the cell at the presented address must not change.
  chk_write_guard: assert property (@(posedge sys_clk) disable iff (rst)
    (state != ppp_pkg::PPP_PROGRAM) |=> mem[$past(prom_address_bits)] == $past(mem[prom_address_bits]))
    else $error("write outside program mode");

  // Data pins of the bus follow the read register one edge after the synchronised address.
  chk_addr_path: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && !vpp_s && !ce_n_s && !oe_n_s)
    |=> port_zero_pins_out == $past(mem[prom_address_bits]))
    else $error("read data not taken from the mapped address");

  // Verify returns the stored byte at the presented address.
  chk_verify_data: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && vpp_s && !oe_n_s) |=> port_zero_pins_out == $past(mem[prom_address_bits]))
    else $error("verify did not return the stored byte");

  // Both enables high float the bus, with or without programming voltage.
  chk_idle_float: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !rst_pin_s && ce_n_s && oe_n_s) |=> port_zero_pins_oe == ppp_pkg::DRIVE_NONE)
    else $error("data bus driven with both enables high");

  // The bus is driven only as a whole byte and only in programming mode.
  chk_drive_lanes: assert property (@(posedge sys_clk) disable iff (rst)
    (port_zero_pins_oe != ppp_pkg::DRIVE_NONE) |-> (port_zero_pins_oe == ppp_pkg::DRIVE_ALL && prog_mode))
    else $error("partial or out of mode bus drive");

  // A released reset pin blocks writes even while program state still stands.
  chk_no_write_run: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rst_pin_s) |-> !write_pulse)
    else $error("write while the reset pin is released");

  // The completion flag lasts one enabled cycle per stored byte.
  chk_done_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && write_done) |=> !write_done)
    else $error("completion flag longer than one cycle");

  // The completion flag only rises after a committed write.
  chk_done_source: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(write_done) |-> $past(write_pulse))
    else $error("completion flag without a write");

  // A low clock enable freezes mode, read data and the completion flag.
  chk_freeze_state: assert property (@(posedge sys_clk) disable iff (rst)
    !clk_en |=> ($stable(state) && $stable(port_zero_pins_out) && $stable(write_done)))
    else $error("state moved while the clock enable was low");
endmodule
`default_nettype wire

// ===== test/ppp_programmer.sv
// Model of the external PROM programmer that drives the programming pins.
`timescale 1ns/1ps
`default_nettype none
module ppp_programmer (
  input wire logic sys_clk,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic [7:0] bus,
  output logic ce_n,
  output logic oe_n,
  output logic vpp,
  output logic [14:0] addr
);
  logic [7:0] drv_data;
  logic drv_en;
  logic [7:0] last;

  // Pins start idle: both enables high, no programming voltage, bus released.
  initial
  begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    vpp = 1'b0;
    addr = 15'h0000;
    drv_data = 8'h00;
    drv_en = 1'b0;
    last = 8'h5A;
  end

  // A released bus shows the inverse of its last level, so a stale byte never passes for a read.
  assign bus = (dev_oe & dev_out) | (~dev_oe & (drv_en ? drv_data : ~last));

  // Remember the resolved level for the floating pattern.
  always @(posedge sys_clk)
    last <= bus;

  // Enables, voltage and address change together just after an edge.
  task automatic set_pins(input logic c, input logic o, input logic v, input logic [14:0] a);
    ce_n <= c;
    oe_n <= o;
    vpp <= v;
    addr <= a;
  endtask

  // The programmer offers data only while the device keeps the bus released.
  task automatic set_data(input logic e, input logic [7:0] d);
    drv_en <= e;
    drv_data <= d;
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench of the programming port against a byte-array model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic reset_pin_n = 1'b1;
  logic [7:0] bus, dout, doe;
  logic ce_n, oe_n, vpp, prog_mode, write_done;
  logic [14:0] addr;
  logic [15:0] seed = 16'hDBE0;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] mem [int];

  // The main clock keeps running through programming mode.
  always #5 sys_clk = ~sys_clk;

  ppp_programmer prog (.sys_clk(sys_clk), .dev_out(dout), .dev_oe(doe), .bus(bus), .ce_n(ce_n),
    .oe_n(oe_n), .vpp(vpp), .addr(addr));

  ppp_port dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reset_pin_n(reset_pin_n),
    .vref_ce_n(ce_n), .port_zero_pins_in(bus), .port_zero_pins_out(dout), .port_zero_pins_oe(doe),
    .port_one_upper_pins(addr[10:4]), .port_two_low_pins(addr[3:0]), .port_three_bit_zero(addr[11]),
    .port_three_bit_one(addr[12]), .port_three_bit_two(oe_n), .port_three_bit_three(vpp),
    .port_four_bit_zero(addr[13]), .port_four_bit_one(addr[14]), .prog_mode(prog_mode),
    .write_done(write_done));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Unwritten cells read as erased.
  function automatic logic [7:0] expb(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  task automatic stop_test;
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Apply enables and address, let the synchroniser settle, then judge the bus.
  task automatic rd(input logic [14:0] a, input logic c, input logic o, input logic v, input logic [7:0] eo);
    cyc(1);
    prog.set_pins(c, o, v, a);
    cyc(5);
    #1;
    chk_byte(doe, eo);
    if (eo == 8'hFF)
      chk_byte(dout, expb(a));
  endtask

  // One program cycle; ok tells whether a store is due.
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic ok);
    int i;
    cyc(1);
    prog.set_pins(1'b1, 1'b1, 1'b0, a);
    prog.set_data(1'b1, d);
    cyc(1);
    prog.set_pins(1'b1, 1'b1, 1'b1, a);
    cyc(4);
    prog.set_pins(1'b0, 1'b1, 1'b1, a);
    for (i = 0; i < 8; i++)
    begin
      cyc(1);
      #1;
      if (write_done === 1'b1)
        break;
    end
    if (ok && i == 8)
    begin
      n_fail++;
      $display("BAD %0t no store pulse", $time);
      stop_test();
    end
    chk_bit(write_done, ok);
    chk_byte(doe, 8'h00);
    if (ok)
      mem[a] = expb(a) & d;
    cyc(1);
    #1;
    chk_bit(write_done, 1'b0);
    cyc(2);
    prog.set_pins(1'b1, 1'b1, 1'b1, a);
    prog.set_data(1'b0, d);
  endtask

  // Main sequence: run mode refusal, walking address bits, rewrites, disable states.
  initial
  begin
    int k;
    logic [14:0] a;
    cyc(10);
    rst <= 1'b0;
    rd(15'h4000, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_bit(prog_mode, 1'b0);
    wr(15'h4001, 8'h00, 1'b0);
    cyc(1);
    reset_pin_n <= 1'b0;
    rd(15'h4001, 1'b0, 1'b0, 1'b0, 8'hFF);
    chk_bit(prog_mode, 1'b1);
    for (k = 0; k < 15; k++)
    begin
      a = 15'h4000 | (15'h0001 << k);
      wr(a, seed[7:0], 1'b1);
      seed = lfsr(seed);
      rd(a, 1'b1, 1'b0, 1'b1, 8'hFF);
    end
    for (k = 0; k < 15; k++)
    begin
      a = 15'h4000 | (15'h0001 << k);
      rd(a, 1'b0, 1'b0, 1'b0, 8'hFF);
      rd(a & 15'h3FFF, 1'b0, 1'b0, 1'b0, 8'hFF);
    end
    for (k = 0; k < 6; k++)
    begin
      a = 15'h4000 | seed[13:0];
      wr(a, seed[15:8], 1'b1);
      seed = lfsr(seed);
      wr(a, seed[7:0], 1'b1);
      seed = lfsr(seed);
      rd(a, 1'b1, 1'b0, 1'b1, 8'hFF);
    end
    // The smaller variant's window, then a frozen clock enable that must hold the bus.
    a = 15'h6000 | seed[12:0];
    wr(a, seed[15:8] & 8'h7F, 1'b1);
    rd(a, 1'b0, 1'b0, 1'b0, 8'hFF);
    cyc(1);
    clk_en <= 1'b0;
    prog.set_pins(1'b0, 1'b0, 1'b0, a ^ 15'h0001);
    cyc(6);
    #1;
    chk_byte(dout, expb(a));
    cyc(1);
    clk_en <= 1'b1;
    cyc(6);
    #1;
    chk_byte(dout, expb(a ^ 15'h0001));
    rd(a, 1'b0, 1'b1, 1'b0, 8'h00);
    rd(a, 1'b1, 1'b0, 1'b0, 8'h00);
    rd(a, 1'b1, 1'b1, 1'b1, 8'h00);
    // A mid-run reset releases the bus and leaves programming mode until the pins resync.
    cyc(1);
    rst <= 1'b1;
    cyc(2);
    #1;
    chk_byte(doe, 8'h00);
    chk_byte(dout, 8'hFF);
    chk_bit(prog_mode, 1'b0);
    cyc(1);
    rst <= 1'b0;
    rd(a, 1'b0, 1'b0, 1'b0, 8'hFF);
    cyc(1);
    reset_pin_n <= 1'b1;
    rd(a, 1'b0, 1'b0, 1'b0, 8'h00);
    chk_bit(prog_mode, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
